// ==== hdl/rsl_reset_loader.sv ====
`timescale 1ns/10ps
`default_nettype none
// Operation
// [RQ1] power-on: pc zero, status 0001 1xxx
// [RQ2] pin reset running: pc zero, upper status cleared
// [RQ3] pin reset asleep: timeout one, powerdown zero
// [RQ4] interrupt wake: pc plus one, to=1, pd=0
// [RQ5] wake with irq enable: pc to vector
// [RQ6] wake leaves source flag, rest kept
// [RQ7] por/bor/parity: pc, option, direction, irq control
// [RQ8] to/pd follow the specific cause
// [RQ9] unimplemented bits read zero; unchanged bits kept
// [RQ10] power-on always sets timeout flag
// [RQ11] power-on always sets powerdown flag
// [RQ12] parity flag set on por/bor, cleared on parity
// [RQ13] watchdog reset to=0 pd=1; wake both zero
module rsl_reset_loader
  import rsl_pkg::*;
(
  input  wire logic             CLK_SYS_I,
  input  wire logic             RSTN_I,
  input  wire logic             WB_CYC_I,
  input  wire logic             WB_STB_I,
  input  wire logic             WB_WE_I,
  input  wire logic [ADR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]       WB_SEL_I,
  input  wire logic [31:0]      WB_DAT_I,
  output var  logic [31:0]      WB_DAT_O,
  output var  logic             WB_ACK_O,
  input  wire logic             POR_I,
  input  wire logic             BOR_I,
  input  wire logic             PARITY_ERR_I,
  input  wire logic             EXTERNAL_RESET_PIN_N_I,
  input  wire logic             WATCHDOG_TIMER_I,
  input  wire logic             PERIPH_IRQ_I,
  output var  logic [PC_W-1:0]  PC_O,
  output var  logic [7:0]       STATUS_O,
  output var  logic             SLEEP_O,
  output var  logic             LOAD_O
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1_q;
  logic rst_n;
  // async assert, release through two stages
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ----------------------------------------
  // event synchronisers
  // ----------------------------------------
  logic [NEV-1:0] ev_raw;
  logic [NEV-1:0] ev_rise;
  // pin is active low, so invert it to an assertion level
  assign ev_raw = {PERIPH_IRQ_I, WATCHDOG_TIMER_I, ~EXTERNAL_RESET_PIN_N_I,
                   PARITY_ERR_I, BOR_I, POR_I};

  genvar gi;
  generate
    for (gi = 0; gi < NEV; gi++) begin : g_sync
      logic s1_q;
      logic s2_q;
      logic s3_q;
      // third stage only feeds the edge detector, never the first
      always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= ev_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      assign ev_rise[gi] = s2_q & ~s3_q;
    end
  endgenerate

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [PC_W-1:0] pc_q, pc_d;
  logic [7:0]      st_q, st_d;
  logic [7:0]      pwr_q, pwr_d;
  logic [7:0]      opt_q, opt_d;
  logic [7:0]      port_b_direction_q, port_b_direction_d;
  logic [7:0]      ic_q, ic_d;
  logic [7:0]      pirq_q, pirq_d;
  logic            sleep_q, sleep_d;
  logic            boot_q;
  logic            load_q;
  rsl_cause_t      cause_q, cause_d;
  logic            ack_q;
  logic [31:0]     dat_q;

  // ----------------------------------------
  // cause priority
  // ----------------------------------------
  logic evt_por, tk_por, tk_bor, tk_per, tk_ext, tk_wdt, tk_irq;
  logic any_hi, wdt_wake, irq_wake, ext_sleep;
  // first cycle after release counts as a power-on event
  assign evt_por   = ev_rise[EV_POR] | boot_q;
  assign tk_por    = evt_por;
  assign tk_bor    = ev_rise[EV_BOR] & ~tk_por;
  assign tk_per    = ev_rise[EV_PER] & ~tk_por & ~tk_bor;
  assign any_hi    = tk_por | tk_bor | tk_per;
  assign tk_ext    = ev_rise[EV_EXT] & ~any_hi;
  assign tk_wdt    = ev_rise[EV_WDT] & ~any_hi & ~tk_ext;
  assign tk_irq    = ev_rise[EV_IRQ] & ~any_hi & ~tk_ext & ~tk_wdt;
  assign ext_sleep = tk_ext & sleep_q;
  assign wdt_wake  = tk_wdt & sleep_q;
  assign irq_wake  = tk_irq & sleep_q;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic        wb_req, wr_fire, wr_lo, wr_hi;
  logic        sel_pc, sel_st, sel_pw, sel_op, sel_tb, sel_ic, sel_pi, sel_ct;
  logic        sel_cause;
  logic [31:0] rd_data;
  assign wb_req  = WB_CYC_I & WB_STB_I;
  // write lands on the edge where the master samples ack
  assign wr_fire = wb_req & WB_WE_I & ack_q;
  assign wr_lo   = wr_fire & WB_SEL_I[0];
  assign wr_hi   = wr_fire & WB_SEL_I[1];
  assign sel_pc  = (WB_ADR_I == ADR_PC);
  assign sel_st  = (WB_ADR_I == ADR_STATUS);
  assign sel_pw  = (WB_ADR_I == ADR_PWR);
  assign sel_op  = (WB_ADR_I == ADR_OPTION);
  assign sel_tb  = (WB_ADR_I == ADR_PORT_B_DIRECTION);
  assign sel_ic  = (WB_ADR_I == ADR_IRQCTL);
  assign sel_pi  = (WB_ADR_I == ADR_PIRQ);
  assign sel_ct  = (WB_ADR_I == ADR_CTRL);
  assign sel_cause = (WB_ADR_I == ADR_CAUSE);

  // read mux; unmapped and unimplemented bits read zero
  always_comb begin
    if (sel_pc) begin
      rd_data = {19'h0, pc_q};
    end else if (sel_st) begin
      rd_data = {24'h0, st_q};
    end else if (sel_pw) begin
      rd_data = {24'h0, pwr_q & PWR_MASK}; // RQ9
    end else if (sel_op) begin
      rd_data = {24'h0, opt_q};
    end else if (sel_tb) begin
      rd_data = {24'h0, port_b_direction_q};
    end else if (sel_ic) begin
      rd_data = {24'h0, ic_q};
    end else if (sel_pi) begin
      rd_data = {24'h0, pirq_q & PIRQ_MASK}; // RQ9
    end else if (sel_ct) begin
      rd_data = {31'h0, sleep_q};
    end else if (sel_cause) begin
      rd_data = {25'h0, cause_q};
    end else begin
      rd_data = 32'h0;
    end
  end

  // ----------------------------------------
  // next state: software writes, then loads
  // ----------------------------------------
  // loads come last so a cause event wins over a same-cycle write
  always_comb begin
    pc_d    = pc_q;
    st_d    = st_q;
    pwr_d   = pwr_q;
    opt_d   = opt_q;
    port_b_direction_d = port_b_direction_q;
    ic_d    = ic_q;
    pirq_d  = pirq_q;
    sleep_d = sleep_q;
    cause_d = cause_q;
    if (wr_lo && sel_pc) pc_d[7:0] = WB_DAT_I[7:0];
    if (wr_hi && sel_pc) pc_d[PC_W-1:8] = WB_DAT_I[PC_W-1:8];
    if (wr_lo && sel_st) st_d = WB_DAT_I[7:0];
    if (wr_lo && sel_pw) pwr_d = WB_DAT_I[7:0] & PWR_MASK; // RQ9
    if (wr_lo && sel_op) opt_d = WB_DAT_I[7:0];
    if (wr_lo && sel_tb) port_b_direction_d = WB_DAT_I[7:0];
    if (wr_lo && sel_ic) ic_d = WB_DAT_I[7:0];
    if (wr_lo && sel_pi) pirq_d = WB_DAT_I[7:0] & PIRQ_MASK; // RQ9
    if (wr_lo && sel_ct) sleep_d = WB_DAT_I[CT_SLEEP];
    // a request sets its flag even when not asleep; set beats a software clear, a hard load below clears it
    if (ev_rise[EV_IRQ]) pirq_d[PI_WAKE] = 1'b1; // RQ6
    if (any_hi) begin
      pc_d    = PC_RESET; // RQ7
      opt_d   = OPT_RESET; // RQ7
      port_b_direction_d = TRIS_RESET; // RQ7
      ic_d    = {IC_CLR, ic_q[IC_PINCHG]}; // RQ7
      pirq_d  = 8'h00;
      sleep_d = 1'b0;
    end
    if (tk_por) begin
      st_d = {ST_UP_CLR, 1'b1, 1'b1, st_q[2:0]}; // RQ1 RQ10 RQ11
      pwr_d[PW_PER] = 1'b1; // RQ12
      pwr_d[PW_POR] = 1'b0;
      cause_d = RSL_C_POR;
    end else if (tk_bor) begin
      st_d = {ST_UP_CLR, 1'b1, 1'b1, st_q[2:0]}; // RQ8
      pwr_d[PW_PER] = 1'b1; // RQ12
      pwr_d[PW_BOR] = 1'b0;
      cause_d = RSL_C_BOR;
    end else if (tk_per) begin
      st_d = {st_q[7:5], 1'b1, 1'b0, st_q[2:0]}; // RQ8
      pwr_d[PW_PER] = 1'b0; // RQ12
      cause_d = RSL_C_PER;
    end else if (tk_ext || (tk_wdt && !sleep_q)) begin
      pc_d    = PC_RESET;
      opt_d   = OPT_RESET;
      port_b_direction_d = TRIS_RESET;
      ic_d    = {IC_CLR, ic_q[IC_PINCHG]};
      sleep_d = 1'b0;
      if (ext_sleep) begin
        st_d = {ST_UP_CLR, 1'b1, 1'b0, st_q[2:0]}; // RQ3
        cause_d = RSL_C_EXT;
      end else if (tk_ext) begin
        st_d = {ST_UP_CLR, st_q[4:0]}; // RQ2
        cause_d = RSL_C_EXT;
      end else begin
        st_d = {ST_UP_CLR, 1'b0, 1'b1, st_q[2:0]}; // RQ13
        cause_d = RSL_C_WDR;
      end
    end else if (wdt_wake) begin
      pc_d = pc_q + PC_ONE; // RQ13
      st_d = {st_q[7:5], 1'b0, 1'b0, st_q[2:0]}; // RQ8
      ic_d[IC_WDWAKE] = 1'b1; // RQ6
      sleep_d = 1'b0;
      cause_d = RSL_C_WDW;
    end else if (irq_wake) begin
      // vector only when the global enable is on
      pc_d = ic_q[IC_GIE] ? IRQ_VECTOR : pc_q + PC_ONE; // RQ4 RQ5
      st_d = {st_q[7:5], 1'b1, 1'b0, st_q[2:0]}; // RQ4
      sleep_d = 1'b0;
      cause_d = RSL_C_IRQ;
    end
  end

  // ----------------------------------------
  // state flops
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      pc_q    <= PC_RESET;
      st_q    <= 8'h00;
      pwr_q   <= 8'h00;
      opt_q   <= OPT_RESET;
      port_b_direction_q <= TRIS_RESET;
      ic_q    <= 8'h00;
      pirq_q  <= 8'h00;
      sleep_q <= 1'b0;
      cause_q <= RSL_C_POR;
      boot_q  <= 1'b1;
    end else begin
      pc_q    <= pc_d;
      st_q    <= st_d;
      pwr_q   <= pwr_d;
      opt_q   <= opt_d;
      port_b_direction_q <= port_b_direction_d;
      ic_q    <= ic_d;
      pirq_q  <= pirq_d;
      sleep_q <= sleep_d;
      cause_q <= cause_d;
      boot_q  <= 1'b0;
    end
  end

  // bus answer one cycle after the request, then drop
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      ack_q  <= 1'b0;
      dat_q  <= 32'h0;
      load_q <= 1'b0;
    end else begin
      ack_q  <= wb_req & ~ack_q;
      dat_q  <= (wb_req & ~ack_q) ? rd_data : 32'h0;
      load_q <= any_hi | tk_ext | tk_wdt | irq_wake;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
  assign PC_O     = pc_q;
  assign STATUS_O = st_q;
  assign SLEEP_O  = sleep_q;
  assign LOAD_O   = load_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!rst_n);

  a_por_load: assert property (tk_por |=> pc_q == PC_RESET && st_q[7:5] == ST_UP_CLR) // RQ1
    else $error("power-on load wrong");
  a_por_timeout: assert property (tk_por |=> st_q[ST_TO]) // RQ10
    else $error("timeout flag not set on power-on");
  a_por_powerdown: assert property (tk_por |=> st_q[ST_PD]) // RQ11
    else $error("powerdown flag not set on power-on");
  a_pin_running: assert property (tk_ext && !sleep_q |=>
      st_q[7:5] == ST_UP_CLR && st_q[4:0] == $past(st_q[4:0]) && pwr_q == $past(pwr_q)) // RQ2
    else $error("pin reset while running changed kept bits");
  a_pin_asleep: assert property (ext_sleep |=> st_q[ST_TO] && !st_q[ST_PD] && !sleep_q) // RQ3
    else $error("pin reset during sleep flags wrong");
  a_irq_wake: assert property (irq_wake && !ic_q[IC_GIE] |=>
      pc_q == $past(pc_q) + PC_ONE && st_q[ST_TO] && !st_q[ST_PD]) // RQ4
    else $error("interrupt wake did not continue");
  a_irq_vector: assert property (irq_wake && ic_q[IC_GIE] |=> pc_q == IRQ_VECTOR) // RQ5
    else $error("interrupt wake missed vector");
  a_wake_source: assert property (wdt_wake || irq_wake |=>
      (ic_q[IC_WDWAKE] || pirq_q[PI_WAKE]) && opt_q == $past(opt_q)) // RQ6
    else $error("wake left no source flag");
  a_hard_defaults: assert property (any_hi |=> pc_q == PC_RESET && opt_q == OPT_RESET
      && port_b_direction_q == TRIS_RESET && ic_q[7:1] == IC_CLR) // RQ7
    else $error("hard reset defaults wrong");
  a_per_flag: assert property (tk_per |=> !pwr_q[PW_PER] ##1 (!pwr_q[PW_PER] || $past(wr_lo && sel_pw))) // RQ12
    else $error("parity flag not cleared");
  a_wdt_flags: assert property (tk_wdt |=> !st_q[ST_TO] && (st_q[ST_PD] == !$past(sleep_q))) // RQ13 RQ8
    else $error("watchdog flags wrong");
  a_unimpl_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:PC_W] == 19'h0) // RQ9
    else $error("unimplemented bits not zero");
endmodule // rsl_reset_loader
`default_nettype wire

// ==== hdl/rsl_pkg.sv ====
package rsl_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int PC_W   = 13;
  // one bit above the eight word slots so the cause word has a home
  localparam int ADR_W  = 6;
  localparam int NEV    = 6;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [ADR_W-1:0] ADR_PC     = 6'h00;
  localparam logic [ADR_W-1:0] ADR_STATUS = 6'h04;
  localparam logic [ADR_W-1:0] ADR_PWR    = 6'h08;
  localparam logic [ADR_W-1:0] ADR_OPTION = 6'h0c;
  localparam logic [ADR_W-1:0] ADR_PORT_B_DIRECTION  = 6'h10;
  localparam logic [ADR_W-1:0] ADR_IRQCTL = 6'h14;
  localparam logic [ADR_W-1:0] ADR_PIRQ   = 6'h18;
  localparam logic [ADR_W-1:0] ADR_CTRL   = 6'h1c;
  localparam logic [ADR_W-1:0] ADR_CAUSE  = 6'h20;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int ST_TO      = 4;
  localparam int ST_PD      = 3;
  localparam int PW_PER     = 2;
  localparam int PW_POR     = 1;
  localparam int PW_BOR     = 0;
  localparam int IC_GIE     = 7;
  localparam int IC_WDWAKE  = 2;
  localparam int IC_PINCHG  = 0;
  localparam int PI_WAKE    = 0;
  localparam int CT_SLEEP   = 0;
  // event input index
  localparam int EV_POR = 0;
  localparam int EV_BOR = 1;
  localparam int EV_PER = 2;
  localparam int EV_EXT = 3;
  localparam int EV_WDT = 4;
  localparam int EV_IRQ = 5;
  // ----------------------------------------
  // load values and masks
  // ----------------------------------------
  localparam logic [PC_W-1:0] PC_RESET   = 13'h0000;
  localparam logic [PC_W-1:0] PC_ONE     = 13'h0001;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [2:0]      ST_UP_CLR  = 3'h0;
  localparam logic [7:0]      OPT_RESET  = 8'hff;
  localparam logic [7:0]      TRIS_RESET = 8'hff;
  localparam logic [6:0]      IC_CLR     = 7'h00;
  localparam logic [7:0]      PWR_MASK   = 8'h07;
  localparam logic [7:0]      PIRQ_MASK  = 8'h01;
  localparam logic [7:0]      CTRL_MASK  = 8'h01;
  // last load cause, one-hot
  typedef enum logic [6:0] {
    RSL_C_POR  = 7'h01,
    RSL_C_BOR  = 7'h02,
    RSL_C_PER  = 7'h04,
    RSL_C_EXT  = 7'h08,
    RSL_C_WDR  = 7'h10,
    RSL_C_WDW  = 7'h20,
    RSL_C_IRQ  = 7'h40
  } rsl_cause_t;
endpackage

// ==== bench/rsl_reset_loader_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module rsl_reset_loader_tb_top;
  import rsl_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic             clk;
  logic             rstn;
  logic             cyc;
  logic             stb;
  logic             we;
  logic [ADR_W-1:0] adr;
  logic [3:0]       sel;
  logic [31:0]      wdat;
  logic [31:0]      rdat;
  logic             ack;
  logic [NEV-1:0]   evs;
  logic [PC_W-1:0]  pc;
  logic [7:0]       st;
  logic             slp;
  logic             load;
  int               miscompares = 0;
  int               comparisons = 0;
  int               cycles = 0;
  localparam int    LIMIT = 5000;

  // pin reset is active low, so the event bit is inverted
  rsl_reset_loader dut_u (
    .CLK_SYS_I(clk), .RSTN_I(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .POR_I(evs[EV_POR]), .BOR_I(evs[EV_BOR]),
    .PARITY_ERR_I(evs[EV_PER]), .EXTERNAL_RESET_PIN_N_I(~evs[EV_EXT]),
    .WATCHDOG_TIMER_I(evs[EV_WDT]), .PERIPH_IRQ_I(evs[EV_IRQ]),
    .PC_O(pc), .STATUS_O(st), .SLEEP_O(slp), .LOAD_O(load)
  );

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ceiling is generous: eleven short tests need well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      $display("MISMATCH t=%0t run did not finish", $time);
      close_out();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input logic [31:0] m, input string what);
    comparisons++;
    if ((got & m) !== (exp & m)) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got & m, exp & m);
    end
  endtask

  // one classic cycle; held until ack is seen high at an edge
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'h1, q);
    chk(q, exp, m, $sformatf("read %h", a));
  endtask

  task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask

  task automatic wload();
    do @(posedge clk); while (load !== 1'b1);
    repeat (4) @(posedge clk);
  endtask

  // raise a cause, hold until the load shows, then leave it low long enough
  task automatic ev(input int k);
    @(posedge clk);
    evs[k] <= 1'b1;
    do @(posedge clk); while (load !== 1'b1);
    evs[k] <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  task automatic tdone(input string n);
    $display("test %s done", n);
  endtask

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'h0;
    wdat = 32'h0;
    evs = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    wload();
    chk(32'(pc), 32'h0, 32'h1fff, "pc");
    rd(ADR_STATUS, 32'h18, 32'hf8);
    rd(ADR_PWR, 32'h04, 32'hfe);
    rd(ADR_OPTION, 32'hff, 32'hff);
    rd(ADR_PORT_B_DIRECTION, 32'hff, 32'hff);
    rd(ADR_IRQCTL, 32'h00, 32'hfe);
    rd(6'h1e, 32'h0, 32'hffffffff);
    rd(ADR_CAUSE, 32'h01, 32'h7f);
    tdone("power_on");
    // pin reset while running: to/pd kept, hard registers reloaded
    wr(ADR_OPTION, 32'h5a, 4'h1);
    wr(ADR_PORT_B_DIRECTION, 32'h3c, 4'h1);
    wr(ADR_PC, 32'h0123, 4'h3);
    ev(EV_EXT);
    chk(32'(pc), 32'h0, 32'h1fff, "pc");
    chk(32'(st), 32'h18, 32'hf8, "status");
    rd(ADR_OPTION, 32'hff, 32'hff);
    rd(ADR_PWR, 32'h04, 32'hff);
    rd(ADR_CAUSE, 32'h08, 32'h7f);
    tdone("pin_running");
    wr(ADR_CTRL, 32'h01, 4'h1);
    ev(EV_EXT);
    chk(32'(st), 32'h10, 32'hf8, "status");
    chk(32'(slp), 32'h0, 32'h1, "sleep");
    tdone("pin_asleep");
    ev(EV_WDT);
    chk(32'(pc), 32'h0, 32'h1fff, "pc");
    chk(32'(st), 32'h08, 32'hf8, "status");
    rd(ADR_CAUSE, 32'h10, 32'h7f);
    tdone("wdt_reset");
    // watchdog wake: other registers must survive
    wr(ADR_OPTION, 32'h5a, 4'h1);
    wr(ADR_PC, 32'h0123, 4'h3);
    wr(ADR_CTRL, 32'h01, 4'h1);
    ev(EV_WDT);
    rd(ADR_PC, 32'h0124, 32'h1fff);
    chk(32'(st), 32'h00, 32'h18, "status");
    rd(ADR_IRQCTL, 32'h04, 32'h04);
    rd(ADR_OPTION, 32'h5a, 32'hff);
    rd(ADR_CAUSE, 32'h20, 32'h7f);
    tdone("wdt_wake");
    // carry out of the low byte on the next-address path
    wr(ADR_IRQCTL, 32'h00, 4'h1);
    wr(ADR_PC, 32'h07ff, 4'h3);
    wr(ADR_CTRL, 32'h01, 4'h1);
    ev(EV_IRQ);
    chk(32'(pc), 32'h0800, 32'h1fff, "pc");
    chk(32'(st), 32'h10, 32'h18, "status");
    rd(ADR_PIRQ, 32'h01, 32'hff);
    rd(ADR_CAUSE, 32'h40, 32'h7f);
    chk(32'(slp), 32'h0, 32'h1, "sleep");
    tdone("irq_wake");
    wr(ADR_IRQCTL, 32'h80, 4'h1);
    wr(ADR_PC, 32'h0055, 4'h3);
    wr(ADR_CTRL, 32'h01, 4'h1);
    ev(EV_IRQ);
    chk(32'(pc), 32'h0004, 32'h1fff, "pc");
    tdone("irq_vector");
    wr(ADR_OPTION, 32'h33, 4'h1);
    // parity flag cleared and brown-out flag set first, so both moves show
    wr(ADR_PWR, 32'h03, 4'h1);
    ev(EV_BOR);
    chk(32'(pc), 32'h0, 32'h1fff, "pc");
    chk(32'(st), 32'h18, 32'h18, "status");
    rd(ADR_PWR, 32'h06, 32'hff);
    rd(ADR_CAUSE, 32'h02, 32'h7f);
    rd(ADR_OPTION, 32'hff, 32'hff);
    rd(ADR_IRQCTL, 32'h00, 32'hfe);
    tdone("brown_out");
    wr(ADR_PC, 32'h0123, 4'h3);
    ev(EV_PER);
    chk(32'(pc), 32'h0, 32'h1fff, "pc");
    chk(32'(st), 32'h10, 32'h18, "status");
    rd(ADR_PWR, 32'h00, 32'h04);
    rd(ADR_CAUSE, 32'h04, 32'h7f);
    tdone("parity");
    ev(EV_POR);
    chk(32'(st), 32'h18, 32'hf8, "status");
    rd(ADR_PWR, 32'h04, 32'hfe);
    tdone("power_on_event");
    // second reset in mid-run: state clears, then a fresh power-on load
    wr(ADR_PC, 32'h0123, 4'h3);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(pc), 32'h0, 32'h1fff, "pc in reset");
    rstn <= 1'b1;
    wload();
    rd(ADR_STATUS, 32'h18, 32'hf8);
    rd(ADR_CAUSE, 32'h01, 32'h7f);
    tdone("second_reset");
    close_out();
  end
endmodule // rsl_reset_loader_tb_top
`default_nettype wire
